// ---- sacc_analog_model.sv ----
// Behavioural analog converter standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sampleHold,
  input wire logic converterPowered,
  input wire sacc_pkg::sacc_chan_t activeChannel,
  input wire logic activeReference,
  output logic [9:0] analogResult
);
  import sacc_pkg::*;
  // Code is set at the sample instant; unpowered it toggles so no stale code survives
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analogResult <= 10'h155;
    end else if (!converterPowered) begin
      analogResult <= ~analogResult;
    end else if (sampleHold) begin
      analogResult <= {activeChannel, activeReference, 7'h2a};
    end
  end
endmodule
`default_nettype wire

// ---- sacc_conversion_control.sv ----
// Successive approximation converter conversion control, top module
//
// Summary of operation
// R1: Result right-justified in two bytes, left-justified when left adjust is set.
// R2: After low byte read, block result updates until high byte is read.
// R3: Conversion finishing while blocked leaves result bytes unchanged, result lost.
// R4: Done flag still sets for a conversion whose result was discarded.
// R5: Reading high byte re-enables result updates to both bytes.
// R6: Start pulse begins one conversion; start bit reads one until done.
// R7: Channel change during conversion waits until that conversion finishes.
// R8: Reference and channel selection reach converter only when enabled.
// R9: Auto trigger rising edge resets prescaler and starts a conversion.
// R10: Trigger edges during conversion ignored; held level does not retrigger.
// R11: Trigger flag sets regardless of interrupt enables; software must clear it. No trigger flag is kept here; the synchronised edge starts directly.
// R12: Done flag as trigger converts back to back; first started by software.
// R13: Software start works with auto trigger; start bit shows every conversion.
// R14: Prescaler runs while enabled, held in reset while disabled.
// R15: Software keeps converter clock in range for full resolution.
// R16: Software start begins at next rising converter clock edge.
// R17: Normal conversion 13 converter clocks, first after enable 25.
// R18: Normal sample-and-hold 1.5 converter clocks after start.
// R19: On completion write result, set done flag, clear start bit if single.
// R20: Auto conversion samples two clocks after trigger, plus three sync cycles.
// R21: Free running restarts right after completion, start bit stays high.
// R22: Selections pass a buffer: tracks idle, locks at start, reopens last cycle.
// R23: Prescaler divides system clock by power of two from divide select.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defs.svh"
module sacc_conversion_control (
  input wire logic clk,
  input wire logic resetn,
  input wire logic converterEnable,
  input wire logic startWrite,
  input wire logic autoTriggerEnable,
  input wire logic freeRunSelect,
  input wire logic triggerLevel,
  input wire logic leftAdjustSelect,
  input wire sacc_pkg::sacc_div_t clockDivideSelect,
  input wire sacc_pkg::sacc_chan_t inputChannelSelect,
  input wire logic referenceSelect,
  input wire logic lowByteRead,
  input wire logic highByteRead,
  input wire logic doneFlagClear,
  input wire logic [9:0] analogResult,
  output logic conversionStartBit,
  output logic conversionDoneFlag,
  output logic [7:0] resultHighByte,
  output logic [7:0] resultLowByte,
  output logic sampleHold,
  output logic converterPowered,
  output sacc_pkg::sacc_chan_t activeChannel,
  output logic activeReference,
  output logic adcClockOut
);
  import sacc_pkg::*;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  sacc_state_t stateReg;
  logic [`SACC_PRESC_W-1:0] prescReg;
  logic adcClkReg;
  logic adcClkPrev;
  logic adcEdge;
  logic [4:0] cycleReg;
  logic [4:0] lengthReg;
  logic [4:0] sampleAtReg;
  logic firstPendingReg;
  logic lockReg;
  logic trigSync;
  logic trigPrevReg;
  logic trigEdge;
  logic [1:0] syncCntReg;
  logic syncBusyReg;
  logic autoStart;
  logic prescReset;
  logic doneNow;
  logic lastCycle;
  logic [9:0] captureReg;
  logic [`SACC_PRESC_W-1:0] divMask;

  // -----------------------------------------------------------------
  // Trigger input synchronisation and edge detect
  // -----------------------------------------------------------------
  sacc_sync u_trigSync (
    .clk(clk),
    .resetn(resetn),
    .din(triggerLevel),
    .dout(trigSync)
  );

  // Previous level kept so a held level never counts as a new edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trigPrevReg <= 1'b0;
    end else begin
      trigPrevReg <= trigSync;
    end
  end

  // Edges seen while a conversion runs are dropped here
  assign trigEdge = autoTriggerEnable && trigSync && !trigPrevReg &&
                    stateReg == SACC_IDLE && !syncBusyReg; // see R10 see R11

  // Third sync cycle before the prescaler is reset and conversion armed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncCntReg <= 2'd0;
      syncBusyReg <= 1'b0;
    end else if (!converterEnable) begin
      syncCntReg <= 2'd0;
      syncBusyReg <= 1'b0;
    end else if (trigEdge) begin
      syncCntReg <= 2'd1;
      syncBusyReg <= 1'b1; // see R20
    end else if (syncBusyReg) begin
      syncCntReg <= syncCntReg + 2'd1;
      if (syncCntReg == `SACC_SYNC_STAGES - 2'd2) begin
        syncBusyReg <= 1'b0;
      end
    end
  end

  assign autoStart = syncBusyReg && syncCntReg == `SACC_SYNC_STAGES - 2'd2; // see R9
  assign prescReset = !converterEnable || autoStart; // see R14 see R9

  // -----------------------------------------------------------------
  // Prescaler
  // -----------------------------------------------------------------
  // Power-of-two divide, selector value n divides by 2^(n+1)
  assign divMask = `SACC_PRESC_W'((1 << clockDivideSelect) - 1); // see R23

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prescReg <= '0;
      adcClkReg <= 1'b0;
    end else if (prescReset) begin
      prescReg <= '0;
      adcClkReg <= 1'b0; // see R14
    end else if ((prescReg & divMask) == divMask) begin
      prescReg <= '0;
      adcClkReg <= ~adcClkReg; // see R23
    end else begin
      prescReg <= prescReg + `SACC_PRESC_W'd1;
    end
  end

  // Rising converter clock edge as a system clock strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      adcClkPrev <= 1'b0;
    end else begin
      adcClkPrev <= adcClkReg;
    end
  end

  assign adcEdge = adcClkReg && !adcClkPrev;

  // Converter clock mirrors the divider, registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      adcClockOut <= 1'b0;
    end else begin
      adcClockOut <= adcClkReg;
    end
  end

  // -----------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------
  assign lastCycle = stateReg == SACC_CONVERT && adcEdge && cycleReg == lengthReg - 5'd1;
  assign doneNow = stateReg == SACC_CONVERT && adcEdge && cycleReg == lengthReg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stateReg <= SACC_IDLE;
      cycleReg <= 5'd0;
      lengthReg <= `SACC_NORMAL_CYCLES;
      sampleAtReg <= `SACC_SAMPLE_NORMAL;
      conversionStartBit <= 1'b0;
    end else if (!converterEnable) begin
      stateReg <= SACC_IDLE;
      cycleReg <= 5'd0;
      conversionStartBit <= 1'b0;
    end else begin
      unique case (stateReg)
        SACC_IDLE: begin
          if (startWrite) begin
            stateReg <= SACC_WAIT_EDGE; // see R16
            conversionStartBit <= 1'b1; // see R6 see R13
          end else if (autoStart) begin
            stateReg <= SACC_CONVERT;
            cycleReg <= 5'd1;
            lengthReg <= firstPendingReg ? `SACC_FIRST_CYCLES : `SACC_NORMAL_CYCLES;
            sampleAtReg <= firstPendingReg ? `SACC_SAMPLE_FIRST : `SACC_SAMPLE_AUTO; // see R20
            conversionStartBit <= 1'b1; // see R13
          end
        end
        SACC_WAIT_EDGE: begin
          if (adcEdge) begin
            stateReg <= SACC_CONVERT;
            cycleReg <= 5'd1;
            lengthReg <= firstPendingReg ? `SACC_FIRST_CYCLES : `SACC_NORMAL_CYCLES; // see R17
            sampleAtReg <= firstPendingReg ? `SACC_SAMPLE_FIRST : `SACC_SAMPLE_NORMAL; // see R18
          end
        end
        SACC_CONVERT: begin
          if (doneNow) begin
            if (autoTriggerEnable && freeRunSelect) begin
              cycleReg <= 5'd1;
              lengthReg <= `SACC_NORMAL_CYCLES;
              sampleAtReg <= `SACC_SAMPLE_NORMAL; // see R21 see R12
            end else begin
              stateReg <= SACC_IDLE;
              cycleReg <= 5'd0;
              conversionStartBit <= 1'b0; // see R19 see R6
            end
          end else if (adcEdge) begin
            cycleReg <= cycleReg + 5'd1;
          end
        end
      endcase
    end
  end

  // First conversion after enable takes the long initialisation path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      firstPendingReg <= 1'b1;
    end else if (!converterEnable) begin
      firstPendingReg <= 1'b1;
    end else if (doneNow) begin
      firstPendingReg <= 1'b0; // see R17
    end
  end

  // Sample strobe half a converter clock after the counted edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sampleHold <= 1'b0;
    end else begin
      sampleHold <= converterEnable && stateReg == SACC_CONVERT && !adcClkReg && adcClkPrev &&
                    cycleReg == sampleAtReg + 5'd1; // see R18 see R20
    end
  end

  // -----------------------------------------------------------------
  // Selection buffer toward the analog side
  // -----------------------------------------------------------------
  // Locks on conversion start so sampling time is never cut short
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lockReg <= 1'b0;
    end else if (stateReg != SACC_CONVERT) begin
      lockReg <= 1'b0;
    end else if (lastCycle) begin
      lockReg <= 1'b0; // see R22
    end else if (cycleReg == 5'd1 && !doneNow) begin
      lockReg <= 1'b1; // see R7
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      activeChannel <= 2'd0;
      activeReference <= 1'b0;
      converterPowered <= 1'b0;
    end else begin
      converterPowered <= converterEnable;
      if (converterEnable && !lockReg && !(stateReg == SACC_CONVERT && cycleReg == 5'd1)) begin
        activeChannel <= inputChannelSelect; // see R8 see R22
        activeReference <= referenceSelect;
      end
    end
  end

  // -----------------------------------------------------------------
  // Result bytes, read lock and done flag
  // -----------------------------------------------------------------
  logic readLockReg;

  // Low byte read blocks updates until the high byte is read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readLockReg <= 1'b0;
    end else if (highByteRead) begin
      readLockReg <= 1'b0; // see R5
    end else if (lowByteRead) begin
      readLockReg <= 1'b1; // see R2
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      captureReg <= `SACC_RESULT_RST;
    end else if (doneNow && !readLockReg) begin
      captureReg <= analogResult; // see R3
    end
  end

  // Alignment applied on the way out so the select acts at once
  always_ff @(posedge clk) begin
    if (!resetn) begin
      resultHighByte <= 8'h00;
      resultLowByte <= 8'h00;
    end else if (leftAdjustSelect) begin
      resultHighByte <= captureReg[9:2];
      resultLowByte <= {captureReg[1:0], 6'h00}; // see R1
    end else begin
      resultHighByte <= {6'h00, captureReg[9:8]};
      resultLowByte <= captureReg[7:0]; // see R1
    end
  end

  // Set wins over clear; raised even when the result was dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conversionDoneFlag <= 1'b0;
    end else if (doneNow) begin
      conversionDoneFlag <= 1'b1; // see R4 see R19
    end else if (doneFlagClear) begin
      conversionDoneFlag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- sacc_conversion_monitor.sv ----
// Assertion checker for the conversion control ports
`timescale 1ns/1ps
`default_nettype none
module sacc_conversion_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic converterEnable,
  input wire logic startWrite,
  input wire logic autoTriggerEnable,
  input wire logic freeRunSelect,
  input wire logic lowByteRead,
  input wire logic highByteRead,
  input wire logic doneFlagClear,
  input wire logic conversionStartBit,
  input wire logic conversionDoneFlag,
  input wire logic [7:0] resultHighByte,
  input wire logic [7:0] resultLowByte,
  input wire logic sampleHold,
  input wire logic converterPowered,
  input wire sacc_pkg::sacc_chan_t activeChannel,
  input wire logic activeReference,
  input wire logic adcClockOut
);
  import sacc_pkg::*;
  logic lockReg;
  logic [5:0] edgeCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Read lock as the core sees it; a high read always frees it
  always_ff @(posedge clk) begin
    if (!resetn || highByteRead) begin
      lockReg <= 1'b0;
    end else if (lowByteRead) begin
      lockReg <= 1'b1;
    end
  end
  // Converter edges seen while busy; lags one edge, hence the loose window
  always_ff @(posedge clk) begin
    if (!resetn || !conversionStartBit) begin
      edgeCnt <= 6'h00;
    end else if ($rose(adcClockOut)) begin
      edgeCnt <= edgeCnt + 6'h01;
    end
  end
  start_taken_a: assert property (startWrite && converterEnable && converterPowered
    && !conversionStartBit |=> conversionStartBit) else $error("start not taken");
  done_with_clear_a: assert property ($fell(conversionStartBit) && converterEnable
    |-> conversionDoneFlag) else $error("start bit fell without done flag");
  flag_sticky_a: assert property (conversionDoneFlag && !doneFlagClear && converterEnable
    |=> conversionDoneFlag) else $error("done flag lost");
  power_follow_a: assert property ($past(resetn) |-> converterPowered == $past(converterEnable))
    else $error("power does not follow enable");
  sel_hold_a: assert property (!converterEnable && !converterPowered
    |=> $stable(activeChannel) && $stable(activeReference)) else $error("selection moved");
  prescaler_hold_a: assert property (!converterEnable && !converterPowered |=> !adcClockOut)
    else $error("converter clock runs while disabled");
  read_lock_a: assert property (lockReg && $past(lockReg) && !highByteRead
    |=> $stable(resultHighByte) && $stable(resultLowByte)) else $error("locked bytes changed");
  conv_len_a: assert property ($fell(conversionStartBit) && converterEnable
    |-> edgeCnt inside {[12:16], [24:27]}) else $error("conversion length wrong");
  sample_busy_a: assert property (sampleHold |-> conversionStartBit)
    else $error("sample outside conversion");
  no_retrigger_a: assert property ($fell(conversionStartBit) && !freeRunSelect && !startWrite
    |=> !conversionStartBit) else $error("held trigger restarted");
  free_run_a: assert property (conversionStartBit && autoTriggerEnable && freeRunSelect
    && converterEnable |=> conversionStartBit) else $error("free run start bit dropped");
  cover property (conversionDoneFlag && lockReg);
  cover property ($fell(conversionStartBit));
  cover property (conversionStartBit && freeRunSelect && sampleHold);
endmodule
`default_nettype wire

// ---- sacc_defs.svh ----
// Constants for the converter conversion control block
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_RES_W 10
`define SACC_NORMAL_CYCLES 5'd13
`define SACC_FIRST_CYCLES 5'd25
`define SACC_SAMPLE_NORMAL 5'd1
`define SACC_SAMPLE_FIRST 5'd13
`define SACC_SAMPLE_AUTO 5'd2
`define SACC_SYNC_STAGES 2'd3
`define SACC_PRESC_W 7
`define SACC_RESULT_RST 10'h000
`endif

// ---- sacc_pkg.sv ----
// Types for the converter conversion control block
package sacc_pkg;
  typedef enum logic [1:0] {SACC_IDLE, SACC_WAIT_EDGE, SACC_CONVERT} sacc_state_t;
  typedef logic [2:0] sacc_div_t;
  typedef logic [1:0] sacc_chan_t;
endpackage

// ---- sacc_sync.sv ----
// Two flip-flop synchroniser for one external level
`timescale 1ns/1ps
`default_nettype none
module sacc_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic stage1Reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1Reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1Reg <= din;
      dout <= stage1Reg;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sacc_pkg::*;
  logic clk, resetn, converterEnable, startWrite, autoTriggerEnable, freeRunSelect;
  logic triggerLevel, leftAdjustSelect, referenceSelect, lowByteRead, highByteRead;
  logic doneFlagClear, conversionStartBit, conversionDoneFlag, sampleHold, converterPowered;
  logic activeReference, adcClockOut;
  sacc_div_t clockDivideSelect;
  sacc_chan_t inputChannelSelect, activeChannel;
  logic [9:0] analogResult;
  logic [7:0] resultHighByte, resultLowByte;
  int n_errors, total_checks, waited;
  sacc_conversion_control DUT (.clk, .resetn, .converterEnable, .startWrite,
    .autoTriggerEnable, .freeRunSelect, .triggerLevel, .leftAdjustSelect,
    .clockDivideSelect, .inputChannelSelect, .referenceSelect, .lowByteRead,
    .highByteRead, .doneFlagClear, .analogResult, .conversionStartBit,
    .conversionDoneFlag, .resultHighByte, .resultLowByte, .sampleHold,
    .converterPowered, .activeChannel, .activeReference, .adcClockOut);
  sacc_analog_model far (.clk, .resetn, .sampleHold, .converterPowered, .activeChannel,
    .activeReference, .analogResult);
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] aligned(input logic [9:0] r, input logic left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction
  // Bounded wait for the start bit to reach a level
  task automatic wait_bit(input logic v);
    waited = 0;
    while (conversionStartBit !== v && waited < 200) begin
      @(negedge clk);
      waited++;
    end
  endtask
  task automatic run_conv;
    startWrite = 1'b1;
    @(negedge clk);
    startWrite = 1'b0;
    wait_bit(1'b0);
  endtask
  // First conversion is long; a channel change mid-run must wait
  task automatic test_single;
    fork
      run_conv();
      begin
        repeat (6) @(negedge clk);
        inputChannelSelect = 2'h1;
        @(negedge clk);
        check({14'h0, activeChannel}, 16'h0002);
      end
    join
    check({15'h0, waited >= 48 && waited <= 52}, 16'h0001);
    check({15'h0, conversionDoneFlag}, 16'h0001);
    check({14'h0, activeChannel}, 16'h0001);
    @(negedge clk);
    check({resultHighByte, resultLowByte}, aligned(10'h22a, 1'b0));
    leftAdjustSelect = 1'b1;
    repeat (3) @(negedge clk);
    check({resultHighByte, resultLowByte}, aligned(10'h22a, 1'b1));
    leftAdjustSelect = 1'b0;
    doneFlagClear = 1'b1;
    repeat (3) @(negedge clk);
    doneFlagClear = 1'b0;
  endtask
  // Low read locks both bytes, the flag still rises, a high read reopens
  task automatic test_lock;
    lowByteRead = 1'b1;
    @(negedge clk);
    lowByteRead = 1'b0;
    run_conv();
    check({15'h0, waited >= 24 && waited <= 28}, 16'h0001);
    @(negedge clk);
    check({resultHighByte, resultLowByte}, aligned(10'h22a, 1'b0));
    check({15'h0, conversionDoneFlag}, 16'h0001);
    highByteRead = 1'b1;
    @(negedge clk);
    highByteRead = 1'b0;
    run_conv();
    @(negedge clk);
    check({resultHighByte, resultLowByte}, aligned(10'h12a, 1'b0));
  endtask
  // Held trigger converts once; an edge mid-conversion is dropped
  task automatic test_auto;
    referenceSelect = 1'b1;
    autoTriggerEnable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      triggerLevel = 1'b0;
      repeat (4) @(negedge clk);
      triggerLevel = 1'b1;
      wait_bit(1'b1);
      check({15'h0, waited <= 8}, 16'h0001);
      triggerLevel = 1'(i == 0);
      repeat (4) @(negedge clk);
      triggerLevel = 1'b1;
      wait_bit(1'b0);
      repeat (30) @(negedge clk);
      check({15'h0, conversionStartBit}, 16'h0000);
    end
    check({resultHighByte, resultLowByte}, aligned(10'h1aa, 1'b0));
    triggerLevel = 1'b0;
  endtask
  // Done flag as trigger keeps converting with the start bit high
  task automatic test_free;
    freeRunSelect = 1'b1;
    run_conv();
    check(16'(waited), 16'd200);
    doneFlagClear = 1'b1;
    @(negedge clk);
    doneFlagClear = 1'b0;
    repeat (30) @(negedge clk);
    check({15'h0, conversionDoneFlag}, 16'h0001);
    converterEnable = 1'b0;
    repeat (3) @(negedge clk);
    check({14'h0, conversionStartBit, converterPowered}, 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is near 500 cycles; this limit leaves wide margin
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {resetn, converterEnable, startWrite, autoTriggerEnable, freeRunSelect} = 5'h00;
    {triggerLevel, leftAdjustSelect, referenceSelect, lowByteRead, highByteRead} = 5'h00;
    doneFlagClear = 1'b0;
    // Fast converter clock keeps the run short; only reduced resolution expected
    clockDivideSelect = 3'h0;
    inputChannelSelect = 2'h2;
    n_errors = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    converterEnable = 1'b1;
    @(negedge clk);
    test_single();
    test_lock();
    test_auto();
    test_free();
    report_and_stop();
  end
endmodule
bind sacc_conversion_control sacc_conversion_monitor u_mon (.clk, .resetn, .converterEnable,
  .startWrite, .autoTriggerEnable, .freeRunSelect, .lowByteRead, .highByteRead,
  .doneFlagClear, .conversionStartBit, .conversionDoneFlag, .resultHighByte,
  .resultLowByte, .sampleHold, .converterPowered, .activeChannel, .activeReference,
  .adcClockOut);
`default_nettype wire
